// >>> rtl/pis_seq_regs.vh
`ifndef PIS_SEQ_REGS_VH
`define PIS_SEQ_REGS_VH

// ****************************************************************
// Register offsets on the plain register port
// ****************************************************************
`define PIS_ADDR_CTRL 8'h00
`define PIS_ADDR_STATE 8'h01
`define PIS_ADDR_SHADCTL 8'h02
`define PIS_ADDR_VTB_L 8'h03
`define PIS_ADDR_VTB_H 8'h04
`define PIS_ADDR_VTB_U 8'h05
`define PIS_ADDR_SHADOW 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define PIS_CTRL_HIGH_EN 7
`define PIS_CTRL_LOW_EN 6
`define PIS_CTRL_PRIO_EN 5
`define PIS_CTRL_VEC_EN 4
`define PIS_SHAD_SEL 0
`define PIS_CTRL_WMASK 8'hF0

// ****************************************************************
// Reset values and fixed non-vectored entry addresses
// ****************************************************************
`define PIS_CTRL_RST 8'h10
`define PIS_VTB_RST 24'h000008
`define PIS_NV_HIGH_ADDR 24'h000008
`define PIS_NV_LOW_ADDR 24'h000018

// ****************************************************************
// Execution states
// ****************************************************************
`define PIS_EXEC_MAIN 2'h0
`define PIS_EXEC_LOW 2'h1
`define PIS_EXEC_HIGH 2'h2

// ****************************************************************
// Sequencer shifts and layout
// ****************************************************************
`define PIS_ENTRY_SHIFT 2
`define PIS_TBL_STRIDE_SHIFT 1
`define PIS_CTX_BYTES 13

`endif

// >>> rtl/pis_seq.v
`include "pis_seq_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module pis_seq #(
  parameter NSRC = 82,
  parameter VW = 7
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_we,
  input wire i_re,
  output reg [7:0] o_rdata,
  input wire [NSRC-1:0] i_pending_flag_regs,
  input wire [NSRC-1:0] i_source_enable_bit,
  input wire [NSRC-1:0] i_source_high,
  input wire i_cyc_en,
  input wire i_instr_done,
  input wire i_return_from_irq_instr,
  input wire i_return_from_irq_instr_restore,
  input wire [8*`PIS_CTX_BYTES-1:0] i_ctx,
  input wire [15:0] i_tbl_data,
  output reg o_forced_no_op,
  output reg o_working_we,
  output reg [7:0] o_working_val,
  output reg o_pc_push,
  output reg o_pc_pop,
  output reg o_pc_load,
  output reg [23:0] o_pc_val,
  output reg o_tbl_rd,
  output reg [23:0] o_tbl_addr,
  output reg o_ctx_we,
  output reg [8*`PIS_CTX_BYTES-1:0] o_ctx_val,
  output reg [1:0] o_exec_state
);

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  localparam ST_RUN = 3'h0;
  localparam ST_LAT1 = 3'h1;
  localparam ST_LAT2 = 3'h2;
  localparam ST_LAT3 = 3'h3;
  localparam ST_NV1 = 3'h4;
  localparam ST_NV2 = 3'h5;
  localparam ST_ABORT = 3'h6;
  localparam NCTX = `PIS_CTX_BYTES;

  reg [7:0] ctrl_q;
  reg shad_sel_q;
  reg [23:0] vtb_q;
  reg [2:0] st_q;
  reg low_act_q;
  reg high_act_q;
  reg [VW-1:0] vec_q;
  reg vec_high_q;
  reg [7:0] shadow_q [0:2*NCTX-1];

  wire high_en = ctrl_q[`PIS_CTRL_HIGH_EN];
  wire low_en = ctrl_q[`PIS_CTRL_LOW_EN];
  wire prio_en = ctrl_q[`PIS_CTRL_PRIO_EN];
  wire vec_en = ctrl_q[`PIS_CTRL_VEC_EN];
  wire boundary = i_cyc_en & i_instr_done;

  // ****************************************************************
  // Request resolution
  // ****************************************************************
  // A flag that reads 1 with its enable set is pending; flags are
  // never cleared here, software clears them at the source
  wire [NSRC-1:0] live = i_pending_flag_regs & i_source_enable_bit;
  // With priorities off every source counts as the single high level
  wire [NSRC-1:0] hi_cand = prio_en ? (live & i_source_high) : live;
  wire [NSRC-1:0] lo_cand = prio_en ? (live & ~i_source_high) : {NSRC{1'b0}};

  reg [VW-1:0] hi_vec;
  reg [VW-1:0] lo_vec;
  integer k;
  // Scan downward so the lowest vector number is the last to stick
  always @* begin
    hi_vec = {VW{1'b0}};
    lo_vec = {VW{1'b0}};
    for (k = NSRC - 1; k >= 0; k = k - 1) begin
      if (hi_cand[k]) begin
        hi_vec = k[VW-1:0];
      end
      if (lo_cand[k]) begin
        lo_vec = k[VW-1:0];
      end
    end
  end

  // Acceptance depends on the current level, never on clearing enables
  wire hi_ok = (|hi_cand) & high_en & ~high_act_q;
  wire lo_ok = (|lo_cand) & high_en & low_en & ~low_act_q & ~high_act_q;
  wire take = hi_ok | lo_ok;
  // High wins over a concurrent low; the low stays pending for later
  wire take_hi = hi_ok;
  wire [VW-1:0] take_vec = hi_ok ? hi_vec : lo_vec;

  // The captured request is still valid only if flag, enable and level
  // enable all survive the last instruction before vectoring
  wire still_ok = i_pending_flag_regs[vec_q] & i_source_enable_bit[vec_q] & high_en &
                  (vec_high_q | low_en);

  // Save into the low slot only when a high preempts a low handler
  wire save_slot = prio_en & vec_high_q & low_act_q;
  // Leaving high with a low underneath restores the low context
  wire rest_slot = high_act_q & low_act_q;

  // Table word address is the base plus two bytes per vector; the entry
  // read back is a word address, so it is shifted up into a byte address
  wire [23:0] tbl_next = vtb_q + ({{(24-VW){1'b0}}, vec_q} << `PIS_TBL_STRIDE_SHIFT);
  wire [23:0] entry_addr = {8'h00, i_tbl_data} << `PIS_ENTRY_SHIFT;
  wire [7:0] vec_byte = {{(8-VW){1'b0}}, vec_q};

  // ****************************************************************
  // Entry and return sequencer
  // ****************************************************************
  // All latency cycles issue a forced no-op so the core executes nothing
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_RUN;
      low_act_q <= 1'b0;
      high_act_q <= 1'b0;
      vec_q <= {VW{1'b0}};
      vec_high_q <= 1'b0;
      o_forced_no_op <= 1'b0;
      o_working_we <= 1'b0;
      o_working_val <= 8'h00;
      o_pc_push <= 1'b0;
      o_pc_pop <= 1'b0;
      o_pc_load <= 1'b0;
      o_pc_val <= 24'h000000;
      o_tbl_rd <= 1'b0;
      o_tbl_addr <= 24'h000000;
      o_ctx_we <= 1'b0;
      o_exec_state <= `PIS_EXEC_MAIN;
    end else begin
      o_working_we <= 1'b0;
      o_pc_push <= 1'b0;
      o_pc_pop <= 1'b0;
      o_pc_load <= 1'b0;
      o_tbl_rd <= 1'b0;
      o_ctx_we <= 1'b0;
      if (i_cyc_en) begin
        o_forced_no_op <= 1'b0;
      end
      case (st_q)
        ST_RUN: begin
          if (boundary && i_return_from_irq_instr) begin
            // Return pops PC; the level being left decides what is restored
            o_pc_pop <= 1'b1;
            o_ctx_we <= i_return_from_irq_instr_restore;
            if (high_act_q) begin
              high_act_q <= 1'b0;
            end else begin
              low_act_q <= 1'b0;
            end
          end else if (boundary && take) begin
            // Halt the routine at the boundary and start entry
            vec_q <= take_vec;
            vec_high_q <= take_hi;
            o_forced_no_op <= 1'b1;
            st_q <= vec_en ? ST_LAT1 : ST_NV1;
          end
        end
        ST_LAT1: begin
          if (i_cyc_en) begin
            if (!still_ok) begin
              st_q <= ST_ABORT;
              o_forced_no_op <= 1'b1;
            end else begin
              // Save context, push PC and place vector in working reg, all in this one step
              o_pc_push <= 1'b1;
              o_working_we <= 1'b1;
              o_working_val <= vec_byte;
              o_tbl_addr <= tbl_next;
              o_forced_no_op <= 1'b1;
              if (vec_high_q) begin
                high_act_q <= 1'b1;
              end else begin
                low_act_q <= 1'b1;
              end
              st_q <= ST_LAT2;
            end
          end
        end
        ST_LAT2: begin
          if (i_cyc_en) begin
            o_tbl_rd <= 1'b1;
            o_forced_no_op <= 1'b1;
            st_q <= ST_LAT3;
          end
        end
        ST_LAT3: begin
          if (i_cyc_en) begin
            o_pc_load <= 1'b1;
            o_pc_val <= entry_addr;
            o_forced_no_op <= 1'b1;
            st_q <= ST_RUN;
          end
        end
        ST_NV1: begin
          if (i_cyc_en) begin
            if (!still_ok) begin
              st_q <= ST_ABORT;
              o_forced_no_op <= 1'b1;
            end else begin
              // No table in this mode: push, vector, then a fixed level address
              o_pc_push <= 1'b1;
              o_working_we <= 1'b1;
              o_working_val <= vec_byte;
              o_forced_no_op <= 1'b1;
              if (vec_high_q) begin
                high_act_q <= 1'b1;
              end else begin
                low_act_q <= 1'b1;
              end
              st_q <= ST_NV2;
            end
          end
        end
        ST_NV2: begin
          if (i_cyc_en) begin
            // Fixed level address; software scans for the source
            o_pc_load <= 1'b1;
            o_pc_val <= vec_high_q ? `PIS_NV_HIGH_ADDR : `PIS_NV_LOW_ADDR;
            o_forced_no_op <= 1'b1;
            st_q <= ST_RUN;
          end
        end
        ST_ABORT: begin
          // The capture cycle already showed a no-op; this state adds the
          // one inserted no-op, then the halted routine continues with nothing saved,
          // pushed or written, so the aborted request leaves no trace
          if (i_cyc_en) begin
            st_q <= ST_RUN;
          end
        end
        default: begin
          st_q <= ST_RUN;
        end
      endcase
      // Readable execution level follows the level flags; it lags them by
      // one clock, which software reading the register never notices
      if (high_act_q) begin
        o_exec_state <= `PIS_EXEC_HIGH;
      end else if (low_act_q) begin
        o_exec_state <= `PIS_EXEC_LOW;
      end else begin
        o_exec_state <= `PIS_EXEC_MAIN;
      end
    end
  end

  // ****************************************************************
  // Restore data path
  // ****************************************************************
  // Context data is latched on the return so it is stable with o_ctx_we;
  // the restore slot is the level underneath the one being left
  wire ret_now = (st_q == ST_RUN) & boundary & i_return_from_irq_instr;
  wire [8*NCTX-1:0] rest_bytes;
  genvar g;
  generate
    for (g = 0; g < NCTX; g = g + 1) begin : g_rest
      // Pick byte g of the slot that the return hands back
      assign rest_bytes[8*g+:8] = shadow_q[rest_slot ? NCTX + g : g];
    end
  endgenerate

  // One register for the whole restore word keeps a single driver
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ctx_val <= {8*NCTX{1'b0}};
    end else if (ret_now) begin
      o_ctx_val <= rest_bytes;
    end
  end

  // ****************************************************************
  // Shadow context store
  // ****************************************************************
  // Hardware save takes priority over a software write in the same
  // cycle, so a live context can never be half overwritten
  wire save_now = i_cyc_en & still_ok & (st_q == ST_LAT1 || st_q == ST_NV1);
  wire sw_shadow = i_we && (i_addr >= `PIS_ADDR_SHADOW) &&
                   (i_addr < `PIS_ADDR_SHADOW + NCTX);
  wire [7:0] sh_off = i_addr - `PIS_ADDR_SHADOW;
  generate
    for (g = 0; g < 2 * NCTX; g = g + 1) begin : g_shad
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          shadow_q[g] <= 8'h00;
        end else if (save_now && (g / NCTX) == save_slot) begin
          shadow_q[g] <= i_ctx[8*(g%NCTX)+:8];
        end else if (sw_shadow && (g / NCTX) == shad_sel_q && sh_off == (g % NCTX)) begin
          shadow_q[g] <= i_wdata;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Register port
  // ****************************************************************
  // Control bits change only by software; entry leaves them alone
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= `PIS_CTRL_RST;
      shad_sel_q <= 1'b0;
      vtb_q <= `PIS_VTB_RST;
    end else if (i_we) begin
      case (i_addr)
        `PIS_ADDR_CTRL: ctrl_q <= i_wdata & `PIS_CTRL_WMASK;
        `PIS_ADDR_SHADCTL: shad_sel_q <= i_wdata[`PIS_SHAD_SEL];
        `PIS_ADDR_VTB_L: vtb_q[7:0] <= i_wdata;
        `PIS_ADDR_VTB_H: vtb_q[15:8] <= i_wdata;
        `PIS_ADDR_VTB_U: vtb_q[23:16] <= i_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read data stands one cycle after the strobe; unmapped reads zero
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_re) begin
      if (i_addr >= `PIS_ADDR_SHADOW && i_addr < `PIS_ADDR_SHADOW + NCTX) begin
        o_rdata <= shadow_q[shad_sel_q ? NCTX + sh_off : sh_off];
      end else begin
        case (i_addr)
          `PIS_ADDR_CTRL: o_rdata <= ctrl_q;
          `PIS_ADDR_STATE: o_rdata <= {6'h00, o_exec_state};
          `PIS_ADDR_SHADCTL: o_rdata <= {7'h00, shad_sel_q};
          `PIS_ADDR_VTB_L: o_rdata <= vtb_q[7:0];
          `PIS_ADDR_VTB_H: o_rdata <= vtb_q[15:8];
          `PIS_ADDR_VTB_U: o_rdata <= vtb_q[23:16];
          default: o_rdata <= 8'h00;
        endcase
      end
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule // pis_seq

`default_nettype wire

// >>> test/pis_seq_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "pis_seq_regs.vh"
// ****************
// Sequencer checks
// ****************
module pis_seq_assertions (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_re,
  input wire logic i_cyc_en,
  input wire logic i_instr_done,
  input wire logic i_return_from_irq_instr,
  input wire logic i_return_from_irq_instr_restore,
  input wire logic [15:0] i_tbl_data,
  input wire logic [7:0] o_rdata,
  input wire logic o_forced_no_op,
  input wire logic o_working_we,
  input wire logic o_pc_push,
  input wire logic o_pc_pop,
  input wire logic o_pc_load,
  input wire logic [23:0] o_pc_val,
  input wire logic o_tbl_rd,
  input wire logic o_ctx_we,
  input wire logic [1:0] o_exec_state
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Latency steps: save, then table fetch on a step
  sequence s_save;
    o_pc_push && o_working_we;
  endsequence
  sequence s_fetch;
    o_tbl_rd && i_cyc_en;
  endsequence
  a_rdata_quiet: assert property (!$past(i_re) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  a_save_fetch: assert property (o_tbl_rd |-> $past(o_pc_push && o_working_we))
    else $error("fetch without save");
  a_vec_land: assert property (s_fetch |=> o_pc_load)
    else $error("handler not loaded after fetch");
  a_entry_shift: assert property (s_fetch |=> o_pc_val == {6'h00, $past(i_tbl_data), 2'b00})
    else $error("handler address not entry times four");
  a_latency_nop: assert property (s_save |-> o_forced_no_op ##1 o_forced_no_op)
    else $error("latency cycle not a forced no-op");
  a_ret_pop: assert property (i_return_from_irq_instr && i_cyc_en && i_instr_done && o_exec_state != `PIS_EXEC_MAIN
    |=> o_pc_pop && o_ctx_we == $past(i_return_from_irq_instr_restore))
    else $error("return did not pop or restore");
  a_restore_pop: assert property (o_ctx_we |-> o_pc_pop)
    else $error("restore without pop");
  a_low_takes_high: assert property (o_pc_push && o_exec_state == `PIS_EXEC_LOW
    |-> ##[1:6] o_exec_state == `PIS_EXEC_HIGH)
    else $error("low handler took a low request");
endmodule // pis_seq_assertions

bind pis_seq pis_seq_assertions u_chk (.i_clk, .i_rst_n, .i_re, .i_cyc_en, .i_instr_done, .i_return_from_irq_instr,
  .i_return_from_irq_instr_restore, .i_tbl_data, .o_rdata, .o_forced_no_op, .o_working_we, .o_pc_push, .o_pc_pop,
  .o_pc_load, .o_pc_val, .o_tbl_rd, .o_ctx_we, .o_exec_state);
`default_nettype wire

// >>> test/pis_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Core stand-in
// ****************
module pis_core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_stall,
  input wire logic [23:0] i_tbl_addr,
  input wire logic i_working_we,
  input wire logic [7:0] i_working_val,
  input wire logic i_ctx_we,
  input wire logic [103:0] i_ctx_val,
  output logic o_cyc_en,
  output logic o_instr_done,
  output logic [103:0] o_ctx,
  output logic [15:0] o_tbl_data
);
  logic [103:0] ctx_q;
  // Entry follows its address, so each vector lands on a distinct handler
  assign o_tbl_data = i_tbl_addr[16:1] + 16'h0100;
  assign o_ctx = ctx_q;
  assign o_instr_done = !i_stall; // Stall stands for a multi-cycle instruction
  // Steps held off in reset; core registers take the sequencer's writes
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cyc_en <= 1'b0;
    end else begin
      o_cyc_en <= 1'b1;
      if (i_working_we) ctx_q[15:8] <= i_working_val;
      if (i_ctx_we) ctx_q <= i_ctx_val;
    end
  end
endmodule // pis_core_model
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_we = 1'b0, i_re = 1'b0, i_return_from_irq_instr = 1'b0, i_return_from_irq_instr_restore = 1'b0;
  logic stall = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  logic [81:0] i_pending_flag_regs = 82'h0, i_source_enable_bit = {82{1'b1}}, i_source_high = 82'h100208;
  logic [103:0] m_ctx = 104'hD0C0B0A09080706050403020A1, l_ctx = 104'h1C2B3A4958677685948372615F;
  wire i_cyc_en, i_instr_done, o_forced_no_op, o_working_we, o_pc_push, o_pc_pop, o_pc_load, o_tbl_rd, o_ctx_we;
  wire [103:0] i_ctx, o_ctx_val;
  wire [15:0] i_tbl_data;
  wire [7:0] o_rdata, o_working_val;
  wire [23:0] o_pc_val, o_tbl_addr;
  wire [1:0] o_exec_state;
  int error_cnt = 0, comparisons = 0, n_push = 0, n_nop = 0;
  always #12.5 i_clk = ~i_clk;
  pis_seq DUT (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_we, .i_re, .o_rdata, .i_pending_flag_regs,
    .i_source_enable_bit, .i_source_high, .i_cyc_en, .i_instr_done, .i_return_from_irq_instr, .i_return_from_irq_instr_restore, .i_ctx,
    .i_tbl_data, .o_forced_no_op, .o_working_we, .o_working_val, .o_pc_push, .o_pc_pop, .o_pc_load,
    .o_pc_val, .o_tbl_rd, .o_tbl_addr, .o_ctx_we, .o_ctx_val, .o_exec_state);
  pis_core_model u_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_stall(stall), .i_tbl_addr(o_tbl_addr),
    .i_working_we(o_working_we), .i_working_val(o_working_val), .i_ctx_we(o_ctx_we), .i_ctx_val(o_ctx_val),
    .o_cyc_en(i_cyc_en), .o_instr_done(i_instr_done), .o_ctx(i_ctx), .o_tbl_data(i_tbl_data));
  // Entry and latency cycles counted for the quiet windows
  always @(posedge i_clk) begin
    n_push += o_pc_push;
    n_nop += o_forced_no_op;
  end
  task chk(input [103:0] a, input [103:0] b, input string m);
    comparisons++;
    if (a !== b) begin
      error_cnt++;
      $display("MISMATCH %0t %s: got %0h exp %0h", $time, m, a, b);
    end
  endtask
  task tick;
    @(posedge i_clk);
    #1;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    @(posedge i_clk);
    i_we <= 1'b0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_re <= 1'b1;
    @(posedge i_clk);
    i_re <= 1'b0;
    #1 chk(o_rdata, e, "read data");
  endtask
  task fl(input int i, input logic v);
    @(posedge i_clk);
    i_pending_flag_regs[i] <= v;
  endtask
  task ret(input logic r, input [103:0] c);
    @(posedge i_clk);
    i_return_from_irq_instr <= 1'b1;
    i_return_from_irq_instr_restore <= r;
    @(posedge i_clk);
    i_return_from_irq_instr <= 1'b0;
    #1 chk(o_pc_pop, 1'b1, "pc pop");
    chk(o_ctx_we, r, "restore strobe");
    if (r) chk(o_ctx_val, c, "restored context");
  endtask
  // Vectored handler = table entry at base + 2*vector, shifted by two
  task enter(input [6:0] v, input logic vd, input [23:0] p);
    int n, k;
    logic [23:0] ta;
    k = -1;
    ta = 24'h000080 + {v, 1'b0};
    if (vd) p = {6'h00, ta[16:1] + 16'h0100, 2'b00};
    for (n = 0; n < 40 && !o_forced_no_op; n++) tick;
    for (n = 0; n < 5 && k < 0; n++) begin
      if (o_working_we) chk(o_working_val, v, "vector in working reg");
      if (o_tbl_rd) chk(o_tbl_addr, ta, "table address");
      if (o_pc_load) k = n;
      if (o_pc_load) chk(o_pc_val, p, "handler address");
      tick;
    end
    chk(k, vd ? 3 : 2, "entry latency");
  endtask
  task quiet(input int nops);
    #1;
    n_push = 0;
    n_nop = 0;
    repeat (10) tick;
    chk(n_push, 0, "unexpected entry");
    chk(n_nop, nops, "forced no-op count");
  endtask
  task end_sim;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard: the tests need well under a thousand cycles
  initial begin
    #(25 * 4000);
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim;
  end
  initial begin
    u_core.ctx_q = m_ctx;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(8'h00, 8'h10);
    rd(8'h01, 8'h00);
    rd(8'h03, 8'h08);
    rd(8'h05, 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'hF0);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    $display("Test registers done");
    wr(8'h00, 8'hF0);
    wr(8'h03, 8'h80);
    @(posedge i_clk);
    i_pending_flag_regs <= 82'h228;
    enter(7'd3, 1'b1, 24'h0);
    chk(o_exec_state, 2'h2, "state pins");
    rd(8'h01, 8'h02);
    fl(3, 1'b0);
    ret(1'b1, m_ctx);
    enter(7'd9, 1'b1, 24'h0);
    fl(9, 1'b0);
    ret(1'b1, m_ctx);
    enter(7'd5, 1'b1, 24'h0);
    rd(8'h01, 8'h01);
    @(posedge i_clk);
    u_core.ctx_q <= l_ctx;
    fl(6, 1'b1);
    quiet(0);
    fl(20, 1'b1);
    enter(7'd20, 1'b1, 24'h0);
    rd(8'h01, 8'h02);
    wr(8'h00, 8'hB0);
    wr(8'h02, 8'h01);
    rd(8'h10, l_ctx[7:0]);
    wr(8'h10, 8'h5A);
    wr(8'h02, 8'h00);
    rd(8'h10, m_ctx[7:0]);
    fl(20, 1'b0);
    ret(1'b1, {l_ctx[103:8], 8'h5A});
    rd(8'h01, 8'h01);
    ret(1'b0, 104'h0);
    rd(8'h01, 8'h00);
    $display("Test priority chain done");
    @(posedge i_clk);
    i_pending_flag_regs <= 82'h0;
    u_core.ctx_q <= m_ctx;
    wr(8'h00, 8'hE0);
    fl(7, 1'b1);
    enter(7'd7, 1'b0, 24'h000018);
    fl(7, 1'b0);
    ret(1'b1, m_ctx);
    wr(8'h00, 8'h80);
    fl(7, 1'b1);
    enter(7'd7, 1'b0, 24'h000008);
    fl(2, 1'b1);
    quiet(0);
    @(posedge i_clk);
    i_pending_flag_regs <= 82'h0;
    ret(1'b1, m_ctx);
    $display("Test non-vectored done");
    wr(8'h00, 8'hF0);
    @(posedge i_clk);
    stall <= 1'b1;
    fl(9, 1'b1);
    fl(9, 1'b0);
    @(posedge i_clk);
    stall <= 1'b0;
    quiet(0);
    fl(9, 1'b1);
    fl(9, 1'b0);
    // Capture cycle plus the one inserted no-op
    quiet(2);
    rd(8'h01, 8'h00);
    rd(8'h00, 8'hF0);
    $display("Test abort done");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
